// [logic/ccet_carrier_trip.v]
// Carrier frequency controller with automatic reduction and external fault trip.
`timescale 1ns/100ps
`include "ccet_consts.vh"

module ccet_carrier_trip #(
    parameter TERMINALS = 7,
    parameter SLEW_TICK_CYCLES = `CCET_SLEW_TICK_CYCLES,
    parameter [15:0] LOW_SPEED_FREQ = 16'h01f4,
    parameter [15:0] RAMP_SPAN_FREQ = 16'h01f4
) (
    input wire i_clk_sys, // System clock, 20 MHz.
    input wire i_reset_n, // Asynchronous reset, active low.
    input wire [7:0] i_carrier_freq_setting, // Carrier setting in 0.1 kHz.
    input wire i_load_type_select, // 0 normal duty, 1 light duty.
    input wire [1:0] i_auto_carrier_reduce_select, // Reduction mode code.
    input wire [1:0] i_control_method_select, // Control method code.
    input wire [15:0] i_output_freq, // Output frequency in 0.01 Hz.
    input wire [15:0] i_current_level, // Output current measurement.
    input wire [15:0] i_current_threshold, // Current level for reduction.
    input wire [15:0] i_temp_level, // Heatsink temperature measurement.
    input wire [15:0] i_temp_threshold, // Temperature for reduction.
    input wire i_dc_braking, // DC braking in progress.
    input wire [8*TERMINALS-1:0] i_input_terminal_function, // Function code per terminal.
    input wire [TERMINALS-1:0] i_input_terminals, // Raw terminal levels.
    input wire i_trip_reset_input, // Trip reset request.
    input wire [1:0] i_post_reset_restart_mode, // Restart mode after reset.
    input wire i_run_command, // Run command level.
    output reg [7:0] o_carrier_freq, // Effective carrier in 0.1 kHz.
    output reg o_external_fault_trip, // External fault trip latched.
    output reg o_alarm_output, // Alarm output.
    output reg o_output_enable, // Power stage gate enable.
    output reg o_restart_match_speed, // Restart with speed matching.
    output reg o_reduction_active // Target is below the clamped setting: reduction, DC braking or sensorless limit.
);

// ------------------------------------------------------------------
// Fault terminal synchronisation and decode
// ------------------------------------------------------------------

wire [TERMINALS-1:0] term_sync;
wire [TERMINALS-1:0] fault_hit;

ccet_fault_sync #(
    .WIDTH(TERMINALS)
) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_async(i_input_terminals),
    .o_sync(term_sync)
);

function is_ext_fault;
    input [7:0] code;
    begin
        is_ext_fault = (code == `CCET_FUNC_EXT_FAULT);
    end
endfunction

// A terminal counts only while its function code selects the external fault.
genvar gi;
generate
    for (gi = 0; gi < TERMINALS; gi = gi + 1) begin : g_term
        assign fault_hit[gi] = term_sync[gi] &
            is_ext_fault(i_input_terminal_function[8*gi +: 8]);
    end
endgenerate

wire fault_on = |fault_hit;

// ------------------------------------------------------------------
// Carrier target selection
// ------------------------------------------------------------------

reg [7:0] setting_clamped;
reg [7:0] upper_limit;
reg reduce_enable;
reg reduce_request;
reg [7:0] reduced_target;
reg [7:0] svc_target;
reg [7:0] target;
reg [15:0] ramp_pos;
reg [23:0] ramp_prod;
reg [23:0] ramp_quot;
wire sensorless = (i_control_method_select == `CCET_CTRL_SENSORLESS);

// ------------------------------------------------------------------
// Helper functions
// ------------------------------------------------------------------

function [7:0] min_carrier;
    input [7:0] a;
    input [7:0] b;
    begin
        min_carrier = (a < b) ? a : b;
    end
endfunction

// ------------------------------------------------------------------
// Setting range limit per load type
// ------------------------------------------------------------------

always @* begin
    upper_limit = (i_load_type_select == `CCET_LOAD_LIGHT) ?
        `CCET_CARRIER_MAX_LIGHT : `CCET_CARRIER_MAX_NORMAL;
    if (i_carrier_freq_setting < `CCET_CARRIER_MIN) begin
        setting_clamped = `CCET_CARRIER_MIN;
    end else begin
        setting_clamped = min_carrier(i_carrier_freq_setting, upper_limit);
    end
end

// ------------------------------------------------------------------
// Automatic reduction request
// ------------------------------------------------------------------

always @* begin
    reduce_enable = (setting_clamped >= `CCET_CARRIER_REDUCE_FLOOR);
    case (i_auto_carrier_reduce_select)
        `CCET_REDUCE_CURRENT: begin
            reduce_request = (i_current_level > i_current_threshold);
        end
        `CCET_REDUCE_TEMP: begin
            reduce_request = (i_temp_level > i_temp_threshold);
        end
        default: begin
            reduce_request = 1'b0;
        end
    endcase
end

// Reduction is all or nothing: the target drops straight to the 3 kHz floor.
always @* begin
    if (reduce_enable && (reduce_request || i_dc_braking)) begin
        reduced_target = `CCET_CARRIER_REDUCE_FLOOR;
    end else begin
        reduced_target = setting_clamped;
    end
end

// ------------------------------------------------------------------
// Sensorless vector low-speed carrier
// ------------------------------------------------------------------

// Held at 2 kHz up to the low-speed limit, then rising linearly over the ramp span.
always @* begin
    if (i_output_freq <= LOW_SPEED_FREQ) begin
        ramp_pos = 16'h0000;
    end else if (i_output_freq - LOW_SPEED_FREQ >= RAMP_SPAN_FREQ) begin
        ramp_pos = RAMP_SPAN_FREQ;
    end else begin
        ramp_pos = i_output_freq - LOW_SPEED_FREQ;
    end
    ramp_prod = {16'h0000, reduced_target - `CCET_CARRIER_LOW_SPEED} * {8'h00, ramp_pos};
    if (RAMP_SPAN_FREQ == 16'h0000) begin
        ramp_quot = 24'h000000;
        svc_target = reduced_target;
    end else begin
        ramp_quot = ramp_prod / {8'h00, RAMP_SPAN_FREQ};
        svc_target = `CCET_CARRIER_LOW_SPEED + ramp_quot[7:0];
    end
end

// ------------------------------------------------------------------
// Target after the sensorless limit
// ------------------------------------------------------------------

always @* begin
    if (sensorless) begin
        target = min_carrier(svc_target, reduced_target);
    end else begin
        target = reduced_target;
    end
end

// ------------------------------------------------------------------
// Slew tick and carrier stepping
// ------------------------------------------------------------------

// One step of 0.1 kHz per tick; the default tick of 50 ms gives 2 kHz per second.
reg [31:0] tick_count;
reg [31:0] next_tick;
wire slew_tick = (tick_count >= SLEW_TICK_CYCLES - 1);

always @* begin
    if (slew_tick) begin
        next_tick = 32'h00000000;
    end else begin
        next_tick = tick_count + 32'h00000001;
    end
end

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        tick_count <= 32'h00000000;
    end else begin
        tick_count <= next_tick;
    end
end

// ------------------------------------------------------------------
// Carrier stepping
// ------------------------------------------------------------------

// The carrier slews on every target change; only reset jumps it, loading 3 kHz directly, from which it then slews.
reg [7:0] next_carrier;

always @* begin
    next_carrier = o_carrier_freq;
    if (slew_tick) begin
        if (o_carrier_freq < target) begin
            next_carrier = o_carrier_freq + `CCET_CARRIER_STEP;
        end else if (o_carrier_freq > target) begin
            next_carrier = o_carrier_freq - `CCET_CARRIER_STEP;
        end
    end
end

// ------------------------------------------------------------------
// Carrier output registers
// ------------------------------------------------------------------

wire next_reduction_active = (target < setting_clamped);

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_carrier_freq <= `CCET_CARRIER_RESET;
    end else begin
        o_carrier_freq <= next_carrier;
    end
end

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_reduction_active <= 1'b0;
    end else begin
        o_reduction_active <= next_reduction_active;
    end
end

// ------------------------------------------------------------------
// External fault trip state machine
// ------------------------------------------------------------------

localparam ST_RUN = `CCET_ST_RUN;
localparam ST_TRIP = `CCET_ST_TRIP;
localparam ST_RESTART = `CCET_ST_RESTART;

reg [1:0] state;
reg [1:0] next_state;
reg [1:0] restart_mode;

always @* begin
    next_state = state;
    case (state)
        ST_RUN: begin
            if (fault_on) begin
                next_state = ST_TRIP;
            end
        end
        ST_TRIP: begin
            // A reset only leaves the trip while the synchronised fault is low.
            if (i_trip_reset_input && !fault_on) begin
                next_state = ST_RESTART;
            end
        end
        ST_RESTART: begin
            if (fault_on) begin
                next_state = ST_TRIP;
            end else if (!i_trip_reset_input) begin
                next_state = ST_RUN;
            end
        end
        default: begin
            next_state = ST_RUN;
        end
    endcase
end

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        state <= ST_RUN;
    end else begin
        state <= next_state;
    end
end

reg next_trip;
reg next_alarm;
reg next_enable;
reg next_match;
reg hold_off;

// ------------------------------------------------------------------
// Trip outputs and restart mode
// ------------------------------------------------------------------

// Hold mode keeps the gates off for one cycle after the trip reset input is released.
always @* begin
    hold_off = (restart_mode == `CCET_RESTART_HOLD) && (state == ST_RESTART);
    next_trip = (next_state == ST_TRIP);
    next_alarm = (next_state == ST_TRIP);
    next_enable = (next_state == ST_RUN) && i_run_command && !hold_off;
    next_match = (next_state != ST_TRIP) && (restart_mode == `CCET_RESTART_MATCH);
end

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        restart_mode <= `CCET_RESTART_ZERO;
    end else if (next_state == ST_RESTART && state == ST_TRIP) begin
        restart_mode <= i_post_reset_restart_mode;
    end
end

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        o_external_fault_trip <= 1'b0;
        o_alarm_output <= 1'b0;
        o_output_enable <= 1'b0;
        o_restart_match_speed <= 1'b0;
    end else begin
        o_external_fault_trip <= next_trip;
        o_alarm_output <= next_alarm;
        o_output_enable <= next_enable;
        o_restart_match_speed <= next_match;
    end
end

endmodule

// [logic/ccet_consts.vh]
// Constants for the carrier control and external trip block.
`ifndef CCET_CONSTS_VH
`define CCET_CONSTS_VH

// Carrier frequencies in units of 0.1 kHz.
`define CCET_CARRIER_MIN 8'h14
`define CCET_CARRIER_MAX_NORMAL 8'h96
`define CCET_CARRIER_MAX_LIGHT 8'h64
`define CCET_CARRIER_REDUCE_FLOOR 8'h1e
`define CCET_CARRIER_LOW_SPEED 8'h14
`define CCET_CARRIER_RESET 8'h1e
`define CCET_CARRIER_STEP 8'h01

// Slew of 2 kHz per second is 20 steps of 0.1 kHz per second, one per 50 ms.
`define CCET_SLEW_RATE_STEPS_PER_S 20
`define CCET_CLOCK_HZ 20000000
`define CCET_SLEW_TICK_CYCLES (`CCET_CLOCK_HZ / `CCET_SLEW_RATE_STEPS_PER_S)

// Reduction selector codes.
`define CCET_REDUCE_OFF 2'h0
`define CCET_REDUCE_CURRENT 2'h1
`define CCET_REDUCE_TEMP 2'h2

// Control method and terminal function codes.
`define CCET_CTRL_SENSORLESS 2'h3
`define CCET_FUNC_EXT_FAULT 8'h0c

// Load type select values.
`define CCET_LOAD_NORMAL 1'b0
`define CCET_LOAD_LIGHT 1'b1

// Restart modes after trip reset.
`define CCET_RESTART_ZERO 2'h0
`define CCET_RESTART_MATCH 2'h1
`define CCET_RESTART_HOLD 2'h2

// Trip controller states.
`define CCET_ST_RUN 2'h0
`define CCET_ST_TRIP 2'h1
`define CCET_ST_RESTART 2'h2

`endif

// [logic/ccet_fault_sync.v]
// Two-stage synchroniser for the external fault terminal levels.
`timescale 1ns/100ps
`include "ccet_consts.vh"

module ccet_fault_sync #(
    parameter WIDTH = 7
) (
    input wire i_clk_sys, // System clock.
    input wire i_reset_n, // Asynchronous reset, active low.
    input wire [WIDTH-1:0] i_async, // Raw terminal levels.
    output wire [WIDTH-1:0] o_sync // Synchronised levels.
);

reg [WIDTH-1:0] stage_a;
reg [WIDTH-1:0] stage_b;

always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
        stage_a <= {WIDTH{1'b0}};
        stage_b <= {WIDTH{1'b0}};
    end else begin
        stage_a <= i_async;
        stage_b <= stage_a;
    end
end

assign o_sync = stage_b;

endmodule

// [testbench/ccet_carrier_trip_asserts.sv]
// Checker for the carrier control and external trip block.
`timescale 1ns/100ps
module ccet_chk #(
    parameter TERMINALS = 7
) (
    input wire i_clk_sys, // Clock.
    input wire i_reset_n, // Reset.
    input wire [7:0] i_carrier_freq_setting, // Setting.
    input wire [1:0] i_auto_carrier_reduce_select, // Selector.
    input wire [1:0] i_control_method_select, // Method.
    input wire i_dc_braking, // Braking.
    input wire [8*TERMINALS-1:0] i_input_terminal_function, // Functions.
    input wire [TERMINALS-1:0] i_input_terminals, // Terminals.
    input wire i_trip_reset_input, // Trip reset.
    input wire [7:0] o_carrier_freq, // Carrier.
    input wire o_external_fault_trip, // Trip.
    input wire o_alarm_output, // Alarm.
    input wire o_output_enable, // Gate enable.
    input wire o_reduction_active // Reduction.
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire sv = i_control_method_select == 2'h3;
    trip_rise_a: assert property ($rose(i_input_terminals[0]) &&
        i_input_terminal_function[7:0] == 8'h0c |-> ##3 o_external_fault_trip)
        else $error("trip not raised");
    trip_hold_a: assert property (o_external_fault_trip && !i_trip_reset_input
        |=> o_external_fault_trip) else $error("trip dropped");
    trip_again_a: assert property ((i_input_terminals[0] [*4])
        ##0 o_external_fault_trip |=> o_external_fault_trip) else $error("trip released");
    alarm_trip_a: assert property (o_alarm_output == o_external_fault_trip)
        else $error("alarm differs");
    gates_off_a: assert property (o_external_fault_trip |-> !o_output_enable)
        else $error("gates on in trip");
    carrier_range_a: assert property (o_carrier_freq >= 8'h14 &&
        o_carrier_freq <= 8'h96) else $error("carrier out of range");
    slew_step_a: assert property ($changed(o_carrier_freq) |->
        8'(o_carrier_freq - $past(o_carrier_freq)) inside {8'h01, 8'hff})
        else $error("carrier step wrong");
    slew_gap_a: assert property ($changed(o_carrier_freq) |=>
        $stable(o_carrier_freq) [*3]) else $error("carrier steps too fast");
    reduce_floor_a: assert property (o_reduction_active && !sv |->
        o_carrier_freq >= 8'h1e) else $error("carrier below floor");
    sel_off_a: assert property ((i_auto_carrier_reduce_select == 2'h0 &&
        !i_dc_braking && !sv) [*3] |=> !o_reduction_active) else $error("reduction while off");
    low_set_a: assert property ((i_carrier_freq_setting < 8'h1e && !sv) [*3]
        |=> !o_reduction_active) else $error("reduction below 3 kHz");
    cover property ($rose(o_external_fault_trip));
    cover property ($rose(o_reduction_active));
    cover property ($fell(o_external_fault_trip));
endmodule
bind ccet_carrier_trip ccet_chk #(.TERMINALS(TERMINALS)) u_chk (.i_clk_sys, .i_reset_n,
    .i_carrier_freq_setting, .i_auto_carrier_reduce_select, .i_control_method_select,
    .i_dc_braking, .i_input_terminal_function, .i_input_terminals, .i_trip_reset_input,
    .o_carrier_freq, .o_external_fault_trip, .o_alarm_output, .o_output_enable,
    .o_reduction_active);

// [testbench/ccet_periph.sv]
// Peripheral system model that drives the fault terminals of the block.
`timescale 1ns/100ps
module ccet_periph (
    input wire i_clk_sys, // System clock.
    input wire i_fault, // Fault request from the bench.
    output reg [6:0] o_terminals // Terminal levels, terminal 0 carries the fault.
);
    // The fault line is a driven level, so it never floats between events.
    initial o_terminals = 7'h00;
    always @(posedge i_clk_sys) begin
        o_terminals <= {6'h00, i_fault};
    end
endmodule

// [testbench/tb.sv]
// Testbench for the carrier control and external trip block.
`timescale 1ns/100ps
`include "ccet_consts.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
    reg i_clk_sys = 1'b0;
    reg i_reset_n = 1'b0;
    reg [7:0] set = 8'h32;
    reg load = 1'b0;
    reg [1:0] sel = 2'h0;
    reg [1:0] ctrl = 2'h0;
    reg [15:0] ofq = 16'h0000;
    reg [15:0] cur = 16'h0000;
    reg [15:0] tmp = 16'h0000;
    reg dc = 1'b0;
    reg fault = 1'b0;
    reg trst = 1'b0;
    reg [1:0] rmode = 2'h0;
    reg run = 1'b0;
    wire [6:0] terms;
    wire [7:0] car;
    wire trip, alarm, oen, match, ract;
    integer miscompares = 0;
    integer compares = 0;
    integer n;
    always #25 i_clk_sys = ~i_clk_sys;
    ccet_periph u_periph (.i_clk_sys(i_clk_sys), .i_fault(fault), .o_terminals(terms));
    ccet_carrier_trip #(.SLEW_TICK_CYCLES(4)) u_dut (.i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n), .i_carrier_freq_setting(set), .i_load_type_select(load),
        .i_auto_carrier_reduce_select(sel), .i_control_method_select(ctrl),
        .i_output_freq(ofq), .i_current_level(cur), .i_current_threshold(16'h0100),
        .i_temp_level(tmp), .i_temp_threshold(16'h0050), .i_dc_braking(dc),
        .i_input_terminal_function({48'h0, `CCET_FUNC_EXT_FAULT}), .i_input_terminals(terms),
        .i_trip_reset_input(trst), .i_post_reset_restart_mode(rmode), .i_run_command(run),
        .o_carrier_freq(car), .o_external_fault_trip(trip), .o_alarm_output(alarm),
        .o_output_enable(oen), .o_restart_match_speed(match), .o_reduction_active(ract));
    task cyc(input integer k);
        begin
            repeat (k) @(posedge i_clk_sys);
            #1;
        end
    endtask
    task wcar(input [7:0] v);
        begin
            n = 0;
            while (car !== v && n < 1000) begin
                cyc(1);
                n = n + 1;
            end
            `CHK("carrier", v, car)
            if (n >= 1000) conclude;
        end
    endtask
    task conclude;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task t_current;
        begin
            @(posedge i_clk_sys);
            sel <= `CCET_REDUCE_CURRENT;
            cur <= 16'h0200;
            wcar(8'h1e);
            cyc(2);
            `CHK("active", 1'b1, ract)
            @(posedge i_clk_sys);
            cur <= 16'h0080;
            wcar(8'h32);
            `CHK("slew", 1'b1, (n >= 76 && n <= 84))
        end
    endtask
    task t_temp;
        begin
            @(posedge i_clk_sys);
            sel <= `CCET_REDUCE_TEMP;
            tmp <= 16'h0080;
            wcar(8'h1e);
            @(posedge i_clk_sys);
            sel <= `CCET_REDUCE_OFF;
            cur <= 16'h0200;
            wcar(8'h32);
        end
    endtask
    task t_clamp;
        begin
            @(posedge i_clk_sys);
            set <= 8'h1a;
            sel <= `CCET_REDUCE_CURRENT;
            wcar(8'h1a);
            cyc(3);
            `CHK("active", 1'b0, ract)
            @(posedge i_clk_sys);
            set <= 8'hff;
            sel <= `CCET_REDUCE_OFF;
            wcar(8'h96);
            @(posedge i_clk_sys);
            load <= `CCET_LOAD_LIGHT;
            wcar(8'h64);
            @(posedge i_clk_sys);
            set <= 8'h00;
            wcar(8'h14);
        end
    endtask
    task t_sensorless;
        begin
            @(posedge i_clk_sys);
            load <= `CCET_LOAD_NORMAL;
            set <= 8'h64;
            ctrl <= `CCET_CTRL_SENSORLESS;
            wcar(8'h14);
            cyc(8);
            `CHK("carrier", 8'h14, car)
            `CHK("active", 1'b1, ract)
            @(posedge i_clk_sys);
            ofq <= 16'h02ee;
            wcar(8'h3c);
            @(posedge i_clk_sys);
            ofq <= 16'h03e8;
            wcar(8'h64);
            @(posedge i_clk_sys);
            ctrl <= 2'h0;
            dc <= 1'b1;
            wcar(8'h1e);
            @(posedge i_clk_sys);
            dc <= 1'b0;
        end
    endtask
    task t_trip;
        begin
            @(posedge i_clk_sys);
            rmode <= `CCET_RESTART_MATCH;
            fault <= 1'b1;
            cyc(5);
            `CHK("trip", 1'b1, trip)
            `CHK("alarm", 1'b1, alarm)
            `CHK("gates", 1'b0, oen)
            @(posedge i_clk_sys);
            trst <= 1'b1;
            cyc(3);
            `CHK("trip", 1'b1, trip)
            @(posedge i_clk_sys);
            trst <= 1'b0;
            fault <= 1'b0;
            cyc(6);
            `CHK("trip", 1'b1, trip)
            @(posedge i_clk_sys);
            trst <= 1'b1;
            cyc(3);
            `CHK("trip", 1'b0, trip)
            `CHK("alarm", 1'b0, alarm)
            `CHK("match", 1'b1, match)
            @(posedge i_clk_sys);
            trst <= 1'b0;
            run <= 1'b1;
            cyc(1);
            `CHK("gates", 1'b1, oen)
            @(posedge i_clk_sys);
            rmode <= `CCET_RESTART_HOLD;
            fault <= 1'b1;
            cyc(5);
            `CHK("trip", 1'b1, trip)
            `CHK("gates", 1'b0, oen)
            @(posedge i_clk_sys);
            fault <= 1'b0;
            cyc(6);
            @(posedge i_clk_sys);
            trst <= 1'b1;
            cyc(2);
            `CHK("trip", 1'b0, trip)
            `CHK("match", 1'b0, match)
            @(posedge i_clk_sys);
            trst <= 1'b0;
            cyc(1);
            `CHK("gates", 1'b0, oen)
            cyc(1);
            `CHK("gates", 1'b1, oen)
            @(posedge i_clk_sys);
            fault <= 1'b1;
            i_reset_n <= 1'b0;
            cyc(1);
            `CHK("trip", 1'b0, trip)
            `CHK("gates", 1'b0, oen)
            @(posedge i_clk_sys);
            i_reset_n <= 1'b1;
            cyc(6);
            `CHK("trip", 1'b1, trip)
        end
    endtask
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        wcar(8'h32);
        t_current;
        t_temp;
        t_clamp;
        t_sensorless;
        t_trip;
        conclude;
    end
endmodule
